// File: isa_side_model.sv
// far-side model: dma engine idle level and packet buffer decode
`timescale 1ns/1ns
`default_nettype none
module isa_side_model (
    input wire logic i_clk,
    input wire logic i_suspend,
    input wire logic i_buf_sel,
    output logic o_dma_idle,
    output logic o_buf_hit
);
    logic [1:0] drain_q = 2'h0;
    ////////////////////////////////////////////////////////////////////////
    // dma needs a few cycles to finish its transfer in flight, so the
    // grant is never immediate; it resumes on the first clock edge after suspend drops
    always_ff @(posedge i_clk) begin
        if (!i_suspend) begin
            drain_q <= 2'h0;
        end else if (drain_q != 2'h3) begin
            drain_q <= drain_q + 2'h1;
        end
    end
    assign o_dma_idle = (drain_q == 2'h3);
    // buffer decode only where the testbench points into packet memory
    assign o_buf_hit = i_buf_sel;
endmodule : isa_side_model
`default_nettype wire

// File: mcu_window_address_mapper.sv
// mcu_window_address_mapper: mcu address windows onto flash and isa buses
`timescale 1ns/1ns
`default_nettype none
module mcu_window_address_mapper (
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // mcu access side
    input wire window_mapper_pkg::mcu_req_type i_mcu_req,
    output logic o_mcu_ready,
    output logic o_mcu_unmapped,
    // flash bus
    output window_mapper_pkg::flash_req_type o_flash_req,
    // shared isa bus
    output window_mapper_pkg::isa_req_type o_isa_req,
    output logic o_dma_regs_sel,
    output logic o_dma_suspend,
    input wire logic i_dma_idle,
    input wire logic i_isa_buf_hit
);
    import window_mapper_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register write decode
    logic we_bank;
    logic we_io;
    logic we_mem;
    logic we_own;
    logic [7:0] bank_q;
    logic [7:0] bank_now;
    logic [7:0] io_page_q;
    logic [7:0] io_page_now;
    logic [7:0] mem_page_q;
    logic [7:0] mem_page_now;

    // writes and reads never overlap on this port, so decode is plain
    // an unknown index matches no register and the write is dropped
    always_comb begin
        we_bank = i_reg_wr && (i_reg_addr == REG_FLASH_BANK);
        we_io = i_reg_wr && (i_reg_addr == REG_IO_PAGE);
        we_mem = i_reg_wr && (i_reg_addr == REG_MEM_PAGE);
        we_own = i_reg_wr && (i_reg_addr == REG_OWNERSHIP);
    end

    // flash bank select, zero after reset
    page_reg #(
        .WIDTH(8),
        .RESET_VALUE(FLASH_BANK_RESET)
    ) u_bank (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(we_bank),
        .i_wdata(i_reg_wdata),
        .o_value(bank_q),
        .o_next(bank_now)
    );

    // isa i/o page base
    page_reg #(
        .WIDTH(8),
        .RESET_VALUE(IO_PAGE_RESET)
    ) u_io_page (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(we_io),
        .i_wdata(i_reg_wdata),
        .o_value(io_page_q),
        .o_next(io_page_now)
    );

    // isa memory page base
    page_reg #(
        .WIDTH(8),
        .RESET_VALUE(MEM_PAGE_RESET)
    ) u_mem_page (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_we(we_mem),
        .i_wdata(i_reg_wdata),
        .o_value(mem_page_q),
        .o_next(mem_page_now)
    );

    ////////////////////////////////////////////////////////////////////////
    // isa ownership arbitration
    logic own_req_q;
    logic own_grant_q;

    // bit 0 of the ownership register requests the isa bus for the mcu
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            own_req_q <= 1'b0;
        end else if (we_own) begin
            own_req_q <= i_reg_wdata[0];
        end
    end

    // grant waits for the dma engine to go idle so no transfer is torn
    // the grant flop is what software polls in the status register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            own_grant_q <= 1'b0;
        end else if (!own_req_q) begin
            own_grant_q <= 1'b0;
        end else if (i_dma_idle) begin
            own_grant_q <= 1'b1;
        end
    end

    // dma held off from request until the grant is dropped again
    assign o_dma_suspend = own_req_q || own_grant_q;

    // release cuts mcu isa access at once, while the grant flop still
    // drops a cycle later, so no mcu cycle goes out after dma resumes
    logic isa_owned;
    assign isa_owned = own_req_q && own_grant_q;

    ////////////////////////////////////////////////////////////////////////
    // window decode, uses forwarded page values
    logic hit_flash;
    logic hit_io;
    logic hit_mem;
    logic isa_hit;
    logic isa_blocked;

    // code fetches only see the flash window; isa windows are data only
    always_comb begin
        hit_flash = i_mcu_req.valid
            && (i_mcu_req.addr[15:14] == FLASH_WIN_HI);
        hit_io = i_mcu_req.valid && !i_mcu_req.code_space
            && (i_mcu_req.addr[15:8] == IO_WIN_HI);
        hit_mem = i_mcu_req.valid && !i_mcu_req.code_space
            && (i_mcu_req.addr[15:12] == MEM_WIN_HI);
        isa_hit = hit_io || hit_mem;
        // memory cycles into packet buffers are refused to the mcu
        isa_blocked = hit_mem && i_isa_buf_hit;
    end

    // isa requests stall until granted; flash and others never stall
    // the mcu holds its request while ready is low, so nothing is queued
    always_comb begin
        o_mcu_ready = !isa_hit || isa_owned;
    end

    ////////////////////////////////////////////////////////////////////////
    // flash bus cycle register
    // every flash window access launches exactly one flash cycle on the next edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_flash_req <= '0;
        end else begin
            o_flash_req.valid <= hit_flash;
            o_flash_req.write <= i_mcu_req.write;
            o_flash_req.addr <= {bank_now[BANK_BITS-1:0],
                i_mcu_req.addr[FLASH_OFS_BITS-1:0]};
            o_flash_req.wdata <= i_mcu_req.wdata;
        end
    end

    // isa bus cycle register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_isa_req <= '0;
            o_dma_regs_sel <= 1'b0;
        end else begin
            o_isa_req.valid <= isa_hit && isa_owned && !isa_blocked;
            o_isa_req.io_cycle <= hit_io;
            o_isa_req.write <= i_mcu_req.write;
            o_isa_req.wdata <= i_mcu_req.wdata;
            if (hit_io) begin
                o_isa_req.addr <= {4'h0, io_page_now,
                    i_mcu_req.addr[7:0]};
            end else begin
                o_isa_req.addr <= {mem_page_now,
                    i_mcu_req.addr[MEM_OFS_BITS-1:0]};
            end
            o_dma_regs_sel <= hit_io && isa_owned
                && (io_page_now == DMA_IO_PAGE);
        end
    end

    // a refused or undecoded access is flagged for the cycle after
    // it completes at once, so a stray address never hangs the mcu
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_mcu_unmapped <= 1'b0;
        end else begin
            o_mcu_unmapped <= (isa_blocked && isa_owned)
                || (i_mcu_req.valid && !hit_flash && !isa_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe
    // idle cycles return zero so stale data is never mistaken for a read
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                REG_FLASH_BANK: o_reg_rdata <= bank_q;
                REG_IO_PAGE: o_reg_rdata <= io_page_q;
                REG_MEM_PAGE: o_reg_rdata <= mem_page_q;
                REG_OWNERSHIP: o_reg_rdata <= {7'h00, own_req_q};
                REG_STATUS: o_reg_rdata <= {6'h00, o_dma_suspend,
                    own_grant_q};
                default: o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all checks run on the core clock and all but a_bank_reset_zero rest during reset; the address
    // maps skip same-cycle register writes, which a_write_applies covers for the bank register only

    // a flash cycle only ever follows an access inside the flash window
    a_flash_window: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_flash_req.valid |-> $past(i_mcu_req.valid)
        && $past(i_mcu_req.addr[15:14]) == FLASH_WIN_HI)
        else $error("flash cycle outside its window");

    // code and data accesses reach the flash window in the same way
    a_flash_both_spaces: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_mcu_req.valid && i_mcu_req.addr[15:14] == FLASH_WIN_HI
        |=> o_flash_req.valid && !o_isa_req.valid)
        else $error("flash window access not routed to flash");

    // an access that hits no window is flagged and starts no cycle
    a_unmapped_flag: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_mcu_req.valid && !hit_flash && !isa_hit
        |=> o_mcu_unmapped && !o_flash_req.valid && !o_isa_req.valid)
        else $error("undecoded access not flagged");

    // bank bits on top, mcu offset below
    a_flash_addr_map: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_flash && !we_bank |=> o_flash_req.valid
        && o_flash_req.addr == {$past(bank_q[5:0]),
        $past(i_mcu_req.addr[13:0])})
        else $error("flash address not built from bank and offset");

    // the bank register comes out of reset at page zero
    a_bank_reset_zero: assert property (
        @(posedge i_clk)
        $past(i_rst) |-> bank_q == FLASH_BANK_RESET)
        else $error("bank register not zero after reset");

    // io page byte over the low address byte, upper nibble zero
    a_io_addr_map: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_io && isa_owned && !we_io |=> o_isa_req.valid
        && o_isa_req.io_cycle && o_isa_req.addr == {4'h0,
        $past(io_page_q), $past(i_mcu_req.addr[7:0])})
        else $error("isa i/o address wrong");

    // code fetches never turn into isa cycles
    a_code_not_isa: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_mcu_req.valid && i_mcu_req.code_space |=> !o_isa_req.valid)
        else $error("code fetch reached the isa bus");

    // memory page byte over the window offset
    a_mem_addr_map: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_mem && isa_owned && !i_isa_buf_hit && !we_mem
        |=> o_isa_req.valid && !o_isa_req.io_cycle
        && o_isa_req.addr == {$past(mem_page_q),
        $past(i_mcu_req.addr[11:0])})
        else $error("isa memory address wrong");

    // the dma register select only ever points at i/o page zero
    a_dma_regs_page: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_dma_regs_sel |-> o_isa_req.io_cycle
        && o_isa_req.addr[15:8] == DMA_IO_PAGE)
        else $error("dma register select off page zero");

    // an owned i/o access on page zero selects the dma registers
    a_dma_regs_hit: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_io && isa_owned && !we_io && io_page_q == DMA_IO_PAGE
        |=> o_dma_regs_sel)
        else $error("dma registers not selected on page zero");

    // no isa cycle leaves without ownership in the cycle before
    a_isa_needs_grant: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_isa_req.valid |-> $past(isa_owned))
        else $error("isa cycle issued without ownership");

    // an isa access without ownership stalls and launches nothing
    a_stall_no_cycle: assert property (
        @(posedge i_clk) disable iff (i_rst)
        isa_hit && !isa_owned |-> !o_mcu_ready ##1 !o_isa_req.valid)
        else $error("isa access not stalled without ownership");

    // the grant only rises once requested and the dma engine is idle
    a_grant_after_idle: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $rose(own_grant_q) |-> $past(own_req_q) && $past(i_dma_idle))
        else $error("grant given while dma busy or unrequested");

    // dma stays suspended under the grant and under every mcu isa cycle
    a_dma_held: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_isa_req.valid || own_grant_q |-> o_dma_suspend)
        else $error("dma running while mcu owns isa bus");

    // one cycle after release the dma engine runs again
    a_dma_resumes: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !own_req_q ##1 !own_req_q |-> !o_dma_suspend)
        else $error("dma not resumed after release");

    // mcu memory cycles into packet buffers never reach the bus
    a_buf_blocked: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_mem && i_isa_buf_hit |=> !o_isa_req.valid)
        else $error("mcu cycle reached packet buffer");

    // a refused packet buffer access is reported to the mcu
    a_buf_flagged: assert property (
        @(posedge i_clk) disable iff (i_rst)
        hit_mem && i_isa_buf_hit && isa_owned |=> o_mcu_unmapped)
        else $error("refused buffer access not flagged");

    // a bank write in the access cycle already steers that access
    a_write_applies: assert property (
        @(posedge i_clk) disable iff (i_rst)
        we_bank && hit_flash |=> o_flash_req.addr[19:14]
        == $past(i_reg_wdata[5:0]))
        else $error("bank write not applied to next access");

endmodule : mcu_window_address_mapper
`default_nettype wire

// File: mcu_window_address_mapper_tb_top.sv
// testbench: window mapper register port, flash and isa windows
`timescale 1ns/1ns
`default_nettype none
module mcu_window_address_mapper_tb_top;
    import window_mapper_pkg::*;
    logic clk, rst, reg_wr, reg_rd, buf_sel, ready_s, um_s, dsel_s;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_s;
    logic ready, unmapped, dma_sel, dma_susp, dma_idle, buf_hit;
    mcu_req_type mcu_req;
    flash_req_type flash_req, fl_s;
    isa_req_type isa_req, isa_s;
    int error_cnt = 0;
    int n_compared = 0;
    ////////////////////////////////////////////////////////////////////////
    mcu_window_address_mapper dut (.i_clk(clk), .i_rst(rst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_mcu_req(mcu_req),
        .o_mcu_ready(ready), .o_mcu_unmapped(unmapped),
        .o_flash_req(flash_req), .o_isa_req(isa_req),
        .o_dma_regs_sel(dma_sel), .o_dma_suspend(dma_susp),
        .i_dma_idle(dma_idle), .i_isa_buf_hit(buf_hit));
    isa_side_model far (.i_clk(clk), .i_suspend(dma_susp),
        .i_buf_sel(buf_sel), .o_dma_idle(dma_idle), .o_buf_hit(buf_hit));
    ////////////////////////////////////////////////////////////////////////
    // free-running clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // write ends on its taking edge: never call two writes back to back
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr_reg
    // read data stands one cycle only, so it is caught right after the edge
    task rd_reg(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_s = reg_rdata;
        @(posedge clk);
    endtask : rd_reg
    task access(input logic code, input logic w, input logic [15:0] a);
        mcu_req <= '{1'b1, code, w, a, 8'h5A};
        #1 ready_s = ready;
        @(posedge clk);
        mcu_req.valid <= 1'b0;
        #1 fl_s = flash_req;
        isa_s = isa_req;
        um_s = unmapped;
        dsel_s = dma_sel;
        @(posedge clk);
    endtask : access
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd_reg(REG_FLASH_BANK);
        chk(rd_s, 8'h00);
        access(1'b0, 1'b0, 16'h8123);
        chk({fl_s.valid, fl_s.addr}, 24'h100123);
        access(1'b0, 1'b0, 16'h1000);
        chk({um_s, fl_s.valid, isa_s.valid}, 3'h4);
        wr_reg(4'h7, 8'hFF);
        rd_reg(4'h7);
        chk(rd_s, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task t_flash;
        wr_reg(REG_FLASH_BANK, 8'h03);
        access(1'b1, 1'b0, 16'h8123);
        chk({fl_s.valid, fl_s.addr}, 21'h10C123);
        chk(isa_s.valid, 1'b0);
        wr_reg(REG_FLASH_BANK, 8'h3F);
        access(1'b0, 1'b1, 16'hBFFF);
        chk({fl_s.valid, fl_s.write, fl_s.addr}, 22'h3FFFFF);
        chk(fl_s.wdata, 8'h5A);
        // bank write and flash access in one cycle: forwarding must apply
        fork
            wr_reg(REG_FLASH_BANK, 8'h21);
            access(1'b0, 1'b0, 16'h8001);
        join
        chk({fl_s.valid, fl_s.addr}, 24'h184001);
        $display("t_flash done");
    endtask : t_flash
    task t_isa;
        wr_reg(REG_IO_PAGE, 8'h05);
        access(1'b0, 1'b0, 16'h4077);
        chk({ready_s, isa_s.valid}, 2'h0);
        wr_reg(REG_OWNERSHIP, 8'h01);
        for (int i = 0; i < 20 && !rd_s[0]; i++) begin
            rd_reg(REG_STATUS);
        end
        if (rd_s[0] !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        chk(dma_susp, 1'b1);
        access(1'b0, 1'b0, 16'h4077);
        chk({ready_s, isa_s.valid, isa_s.io_cycle}, 3'h7);
        chk(isa_s.addr, 20'h00577);
        access(1'b1, 1'b0, 16'h4077);
        chk({ready_s, isa_s.valid, um_s}, 3'h5);
        wr_reg(REG_IO_PAGE, 8'h00);
        access(1'b0, 1'b0, 16'h4000);
        chk({dsel_s, isa_s.addr}, 21'h100000);
        wr_reg(REG_MEM_PAGE, 8'hAB);
        access(1'b0, 1'b1, 16'h5123);
        chk({isa_s.io_cycle, isa_s.write, isa_s.addr}, 22'h1AB123);
        chk(isa_s.wdata, 8'h5A);
        buf_sel <= 1'b1;
        access(1'b0, 1'b0, 16'h5010);
        chk({isa_s.valid, um_s}, 2'h1);
        buf_sel <= 1'b0;
        wr_reg(REG_OWNERSHIP, 8'h00);
        @(posedge clk);
        #1 chk(dma_susp, 1'b0);
        $display("t_isa done");
    endtask : t_isa
    ////////////////////////////////////////////////////////////////////////
    // reset for six cycles, then the scenarios in turn
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        buf_sel = 1'b0;
        mcu_req = '0;
        rd_s = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_flash();
        t_isa();
        stop_test();
    end
endmodule : mcu_window_address_mapper_tb_top
`default_nettype wire

// File: page_reg.sv
// page_reg: one software-writable page/base register with a reset value
`timescale 1ns/1ns
`default_nettype none
module page_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_value,
    output logic [WIDTH-1:0] o_next
);
    logic [WIDTH-1:0] value_q;

    // the written value is forwarded so a same-cycle access sees it
    always_comb begin
        o_next = i_we ? i_wdata : value_q;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            value_q <= RESET_VALUE;
        end else if (i_we) begin
            value_q <= i_wdata;
        end
    end

    assign o_value = value_q;
endmodule : page_reg
`default_nettype wire

// File: window_mapper_pkg.sv
// package: register map, window decode constants and carrier types
package window_mapper_pkg;

    // register indices on the plain register port
    localparam logic [3:0] REG_FLASH_BANK = 4'h0;
    localparam logic [3:0] REG_IO_PAGE = 4'h1;
    localparam logic [3:0] REG_MEM_PAGE = 4'h2;
    localparam logic [3:0] REG_OWNERSHIP = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // reset values
    localparam logic [7:0] FLASH_BANK_RESET = 8'h00;
    localparam logic [7:0] IO_PAGE_RESET = 8'h00;
    localparam logic [7:0] MEM_PAGE_RESET = 8'h00;

    // window decode: base pattern of the high address bits
    localparam logic [1:0] FLASH_WIN_HI = 2'h2;
    localparam logic [7:0] IO_WIN_HI = 8'h40;
    localparam logic [3:0] MEM_WIN_HI = 4'h5;
    localparam int FLASH_OFS_BITS = 14;
    localparam int MEM_OFS_BITS = 12;
    localparam int BANK_BITS = 6;

    // isa i/o page that holds the dma controller's registers
    localparam logic [7:0] DMA_IO_PAGE = 8'h00;

    // one mcu access request
    typedef struct packed {
        logic valid;
        logic code_space;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mcu_req_type;

    // one cycle on the isa bus
    typedef struct packed {
        logic valid;
        logic io_cycle;
        logic write;
        logic [19:0] addr;
        logic [7:0] wdata;
    } isa_req_type;

    // one cycle on the flash bus
    typedef struct packed {
        logic valid;
        logic write;
        logic [19:0] addr;
        logic [7:0] wdata;
    } flash_req_type;

endpackage : window_mapper_pkg
